// *** rtl/sas_pkg.sv ***
// sas_pkg: constants for the sar converter sequencer
// assumes an 8-bit register map reached over 32-bit wishbone words
package sas_pkg;
  localparam int          SAS_RES_W        = 10;
  localparam int          SAS_CH_N         = 6;
  localparam int          SAS_ADR_W        = 16;
  // printed offsets are word-granular indexes; byte address is index * 4
  localparam logic [15:0] SAS_IDX_RES_LOW  = 16'hf2d0;
  localparam logic [15:0] SAS_IDX_RES_HIGH = 16'hf2d1;
  localparam logic [15:0] SAS_IDX_CONTROL  = 16'hf2f1;
  localparam logic [15:0] SAS_IDX_CHANNEL  = 16'hf2f2;
  localparam logic [7:0]  SAS_RESET_VAL    = 8'h00;
  localparam int          SAS_RUN_BIT      = 0;
  localparam int          SAS_LOW_SHIFT    = 6;
  // analog settle time per approximation step
  localparam int          SAS_STEP_NS      = 100;
  localparam int          SAS_CLK_NS       = 50;
  localparam int          SAS_STEP_CYC     = (SAS_STEP_NS + SAS_CLK_NS - 1) / SAS_CLK_NS;
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_STEP = 2'b01,
    SAS_HOLD = 2'b10
  } sas_state_e;
endpackage

// *** rtl/sas_res_if.sv ***
// sas_res_if: result hand-over between sequencer and result store
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface sas_res_if;
  logic       load;
  logic [9:0] value;
  logic [7:0] high;
  logic [7:0] low;
  modport seq (output load, output value, input high, input low);
  modport store (input load, input value, output high, output low);
endinterface

// *** rtl/sas_result_store.sv ***
// sas_result_store: holds the conversion result split over two bytes
// assumes load is a one-cycle pulse from the sequencer
`timescale 1ns/10ps
module sas_result_store
  import sas_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  sas_res_if.store  res
);
  logic [7:0] high_reg;
  logic [7:0] low_reg;

  // both bytes updated together, only on completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_reg <= SAS_RESET_VAL;
      low_reg  <= SAS_RESET_VAL;
    end else if (res.load) begin
      high_reg <= res.value[9:2];
      low_reg  <= {res.value[1:0], 6'h00};
    end
  end

  assign res.high = high_reg;
  assign res.low  = low_reg;

  a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !res.load |=> $stable(high_reg) && $stable(low_reg))
    else $error("result changed without completion");
endmodule

// *** rtl/sas_seq.sv ***
// sas_seq: wishbone-controlled sequencer for a 10-bit sar converter
// assumes an analog core giving a comparator answer per trial code
`timescale 1ns/10ps
// Operation
// - high result byte holds result bits 9..2, read only.
// - low result byte holds result bits 1..0 in bits 7..6.
// - results reset to zero, load only at conversion completion.
// - run bit 0 writes one to start, zero to stop; resets zero.
// - channel register bits 0..5 enable inputs; bits 7..6 read zero.
// - run with no channel powers converter, no conversion, run stays one.
// - on finish store result and raise conversion done interrupt.
// - channel latched at start and used until completion.
// - results unchanged when no channel is enabled.
module sas_seq
  import sas_pkg::*;
#(
  parameter int STEP_CYC = SAS_STEP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        comp_i,
  output logic      [9:0]  trial_o,
  output logic      [5:0]  channel_o,
  output logic             powered_o,
  output logic             sample_o,
  output logic             conversion_done_irq_o
);
  sas_state_e  state_reg, state_next;
  logic        run_reg;
  logic [5:0]  chan_reg;
  logic [5:0]  lat_reg;
  logic [9:0]  sar_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  cnt_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        irq_reg;
  sas_res_if   res ();

  // address decode
  wire        req      = cyc_i && stb_i && !ack_reg;
  wire [15:0] idx      = adr_i[17:2];
  wire        hit_low  = idx == SAS_IDX_RES_LOW;
  wire        hit_high = idx == SAS_IDX_RES_HIGH;
  wire        hit_ctl  = idx == SAS_IDX_CONTROL;
  wire        hit_chn  = idx == SAS_IDX_CHANNEL;
  wire        hit      = hit_low || hit_high || hit_ctl || hit_chn;
  wire        wr_ctl   = req && we_i && sel_i[0] && hit_ctl;
  wire        wr_chn   = req && we_i && sel_i[0] && hit_chn;
  wire [7:0]  rd_byte  = hit_low  ? res.low :
                         hit_high ? res.high :
                         hit_ctl  ? {7'h00, run_reg} :
                         hit_chn  ? {2'b00, chan_reg} : 8'h00;
  wire        any_chan = |chan_reg;
  wire        step_end = state_reg == SAS_STEP && cnt_reg == 8'(STEP_CYC - 1);
  wire        last_bit = bit_reg == 4'h0;
  wire        finish   = step_end && last_bit;
  // set wins over the automatic clear
  wire        run_next = wr_ctl ? dat_i[SAS_RUN_BIT] :
                         finish ? 1'b0 : run_reg;

  // bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= hit ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end
  assign ack_o = ack_reg && cyc_i;
  assign err_o = 1'b0;
  assign dat_o = dat_reg; // registered, zero when unmapped

  // control and channel registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg  <= 1'b0;
      chan_reg <= 6'h00;
    end else begin
      run_reg <= run_next;
      if (wr_chn) begin
        chan_reg <= dat_i[5:0];
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SAS_IDLE: begin
        if (run_reg && any_chan) begin
          state_next = SAS_STEP;
        end
      end
      SAS_STEP: begin
        if (!run_reg) begin
          state_next = SAS_IDLE;
        end else if (finish) begin
          state_next = SAS_HOLD;
        end
      end
      SAS_HOLD: begin
        state_next = SAS_IDLE;
      end
      default: begin
        state_next = SAS_IDLE;
      end
    endcase
  end

  // approximation datapath, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SAS_IDLE;
      lat_reg   <= 6'h00;
      sar_reg   <= 10'h000;
      bit_reg   <= 4'h0;
      cnt_reg   <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      irq_reg   <= finish && run_reg;
      if (state_reg == SAS_IDLE) begin
        lat_reg <= chan_reg;
        sar_reg <= 10'(1 << (SAS_RES_W - 1));
        bit_reg <= 4'(SAS_RES_W - 1);
        cnt_reg <= 8'h00;
      end else if (state_reg == SAS_STEP) begin
        cnt_reg <= step_end ? 8'h00 : cnt_reg + 8'h01;
        if (step_end) begin
          sar_reg[bit_reg] <= comp_i;
          if (!last_bit) begin
            sar_reg[bit_reg - 4'h1] <= 1'b1;
            bit_reg <= bit_reg - 4'h1;
          end
        end
      end
    end
  end

  // completed value handed to the result store
  assign res.load  = finish && run_reg;
  always_comb begin
    res.value          = sar_reg;
    res.value[bit_reg] = comp_i;
  end

  sas_result_store u_store (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .res   (res)
  );

  assign trial_o               = sar_reg;
  assign channel_o             = lat_reg;
  assign powered_o             = run_reg;
  assign sample_o              = state_reg == SAS_STEP;
  assign conversion_done_irq_o = irq_reg;

  a_idle_no_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == SAS_IDLE && run_reg && !any_chan && !wr_ctl |=> run_reg && state_reg == SAS_IDLE)
    else $error("conversion ran with no channel");
  a_run_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    finish && run_reg && !wr_ctl |=> !run_reg)
    else $error("run bit not cleared at completion");
  a_done_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    res.load |=> conversion_done_irq_o)
    else $error("done interrupt missing");
  a_channel_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == SAS_STEP |=> $stable(lat_reg))
    else $error("latched channel changed mid conversion");
  a_ctl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl |=> run_reg == $past(dat_i[SAS_RUN_BIT]))
    else $error("run bit write lost");
  a_chan_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && hit_chn |=> dat_o[7:6] == 2'b00 && dat_o[5:0] == chan_reg)
    else $error("channel readback wrong");
  a_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    res.load |=> res.high == $past(res.value[9:2]) && res.low[7:6] == $past(res.value[1:0]))
    else $error("result split wrong");
  a_no_chan_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == SAS_IDLE && !any_chan |=> $stable(res.high) && $stable(res.low))
    else $error("result changed with no channel");
  a_bits_msb: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == SAS_IDLE && state_next == SAS_STEP |=> bit_reg == 4'(SAS_RES_W - 1))
    else $error("conversion not msb first");

  c_conv_done: cover property (@(posedge clk_i) res.load);
  c_stop: cover property (@(posedge clk_i) state_reg == SAS_STEP && !run_reg);
  c_no_chan: cover property (@(posedge clk_i) run_reg && !any_chan);
endmodule

// *** bench/sas_analog_model.sv ***
// sas_analog_model: analog core with one fixed level per input
// assumes a one-hot channel and a steady trial code within each step
`timescale 1ns/10ps
module sas_analog_model #(
  parameter logic [5:0][9:0] LEVELS = '0
) (
  input  wire logic       clk_i,
  input  wire logic [5:0] channel_i,
  input  wire logic [9:0] trial_i,
  input  wire logic       sample_i,
  output logic            comp_o
);
  logic [9:0] vin;
  logic       idle_q = 1'b0;
  // level of the selected input, zero with no channel
  always_comb begin
    vin = 10'h000;
    for (int i = 0; i < 6; i++) begin
      if (channel_i[i]) vin = LEVELS[i];
    end
  end
  // idle answer flips every cycle so a stale compare cannot pass
  always_ff @(posedge clk_i) idle_q <= ~idle_q;
  assign comp_o = sample_i ? (vin >= trial_i) : idle_q;
endmodule

// *** bench/sar_adc_sequencer_bench.sv ***
// sar_adc_sequencer_bench: register-level tests of the converter sequencer
// assumes a 20 MHz clock and the analog core model beside the design
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sar_adc_sequencer_bench import sas_pkg::*; ;
  localparam logic [5:0][9:0] LV = {10'h1ff, 10'h200, 10'h155, 10'h2aa, 10'h000, 10'h3ff};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        comp, ack, irq, pwr, smp, err;
  logic [17:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0, rdat;
  logic [9:0]  trial;
  logic [5:0]  chan;
  logic [7:0]  q;
  int          miscompares = 0, num_checks = 0, irqs = 0, cycles = 0;

  sas_seq #(.STEP_CYC(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .comp_i(comp),
    .trial_o(trial), .channel_o(chan), .powered_o(pwr), .sample_o(smp), .conversion_done_irq_o(irq));
  sas_analog_model #(.LEVELS(LV)) core (.clk_i(clk_i), .channel_i(chan), .trial_i(trial),
    .sample_i(smp), .comp_o(comp));

  initial forever #25 clk_i = ~clk_i;
  // interrupt pulse count and hang guard
  always @(posedge clk_i) begin
    if (irq === 1'b1) irqs++;
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    // ack high ends this wait; without ack only the bench timeout does
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    `CHK(err, 1'b0)
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx);
    wb(1'b0, idx, 8'h00);
  endtask

  // start, retarget channel mid-run, poll run bit until it clears
  task automatic convert(input int ch);
    int n;
    wb(1'b1, SAS_IDX_CHANNEL, 8'(1 << ch));
    wb(1'b1, SAS_IDX_CONTROL, 8'h01);
    wb(1'b1, SAS_IDX_CHANNEL, 8'(1 << ((ch + 1) % 6)));
    `CHK(chan, 6'(1 << ch))
    `CHK(smp, 1'b1)
    n = 0;
    do begin rd(SAS_IDX_CONTROL); n++; end while (q[0] !== 1'b0 && n < 40);
  endtask

  initial begin
    int e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SAS_IDX_RES_HIGH); `CHK(q, 8'h00)
    rd(SAS_IDX_RES_LOW); `CHK(q, 8'h00)
    rd(SAS_IDX_CONTROL); `CHK(q, 8'h00)
    rd(SAS_IDX_CHANNEL); `CHK(q, 8'h00)
    rd(16'h0123); `CHK(q, 8'h00)
    wb(1'b1, SAS_IDX_RES_HIGH, 8'h5a); rd(SAS_IDX_RES_HIGH); `CHK(q, 8'h00)
    wb(1'b1, SAS_IDX_CHANNEL, 8'hc4); rd(SAS_IDX_CHANNEL); `CHK(q, 8'h04)
    $display("test registers done");
    for (int ch = 0; ch < 6; ch++) begin
      e = irqs;
      convert(ch);
      `CHK(q[0], 1'b0)
      rd(SAS_IDX_RES_HIGH); `CHK(q, LV[ch][9:2])
      rd(SAS_IDX_RES_LOW); `CHK(q, {LV[ch][1:0], 6'h00})
      `CHK(trial, 10'h200)
      `CHK(irqs, e + 1)
    end
    $display("test conversions done");
    // start with no channel: powered, run stays, nothing stored
    e = irqs;
    wb(1'b1, SAS_IDX_CHANNEL, 8'h00);
    wb(1'b1, SAS_IDX_CONTROL, 8'h01);
    repeat (40) @(posedge clk_i);
    rd(SAS_IDX_CONTROL); `CHK(q, 8'h01)
    `CHK(pwr, 1'b1)
    rd(SAS_IDX_RES_HIGH); `CHK(q, LV[5][9:2])
    `CHK(irqs, e)
    // stop right after a start: no load, no interrupt
    wb(1'b1, SAS_IDX_CONTROL, 8'h00);
    wb(1'b1, SAS_IDX_CHANNEL, 8'h02);
    wb(1'b1, SAS_IDX_CONTROL, 8'h01);
    wb(1'b1, SAS_IDX_CONTROL, 8'h00);
    repeat (40) @(posedge clk_i);
    rd(SAS_IDX_CONTROL); `CHK(q, 8'h00)
    rd(SAS_IDX_RES_LOW); `CHK(q, {LV[5][1:0], 6'h00})
    `CHK(irqs, e)
    $display("test refusals done");
    stop_test();
  end
endmodule
